/* src/sdw_device.sv */
module sdw_device #(
    parameter int SUPPLY_MV = 3300
) (
    input wire logic ref_clk,                  // System clock.
    input wire logic sys_rst,                  // Asynchronous reset, power-on.
    sdw_link_if.device lnk,                    // Three-wire serial link.
    output logic [7:0] dac_code,               // Stored converter code.
    output sdw_pkg::sdw_mode_t op_mode,        // Current operating mode.
    output logic power_down,                   // Analog section shut down.
    output logic pull_1k_en,                   // Output pulled down by 1k.
    output logic pull_100k_en,                 // Output pulled down by 100k.
    output logic out_hiz,                      // Output in high impedance.
    output logic [12:0] out_mv,                // Ideal output in millivolts.
    output logic written,                      // A valid write was taken.
    output logic update                        // One-cycle pulse per write.
);
    import sdw_pkg::*;

    // Refuses a supply that would overflow the millivolt output.
    if (SUPPLY_MV < 1 || SUPPLY_MV > 8191) begin : g_bad_supply
        $error("SUPPLY_MV out of range");
    end

    // Ideal output level for a code at the given supply.
    function automatic logic [12:0] ideal_mv(logic [7:0] c);
        logic [20:0] p;
        p = 21'(SUPPLY_MV) * 21'(c);
        return p[20:8];
    endfunction

    // ----------------------------------------------------------------
    // Link domain: shift register clocked by the serial clock
    // ----------------------------------------------------------------
    // A high frame select holds the counter and shift register cleared,
    // so only its falling edge can open a frame and an early rise
    // throws the partial word away.
    logic link_clr;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic [15:0] hold;
    logic word_tog;

    assign link_clr = sys_rst | lnk.frame_n;

    always_ff @(negedge lnk.sclk or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != WORD_EDGES) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(negedge lnk.sclk or posedge link_clr) begin
        if (link_clr) begin
            shift <= 16'h0000;
        end else if (bit_cnt != WORD_EDGES) begin
            shift <= {shift[14:0], lnk.din};
        end
    end

    // The word is copied on the sixteenth edge and announced by a toggle.
    // It stays put for at least sixteen more link clocks, far longer
    // than the synchroniser needs.
    always_ff @(negedge lnk.sclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold <= 16'h0000;
            word_tog <= 1'b0;
        end else if (bit_cnt == LAST_EDGE) begin
            hold <= {shift[14:0], lnk.din};
            word_tog <= ~word_tog;
        end
    end

    // ----------------------------------------------------------------
    // Crossing into the system clock domain
    // ----------------------------------------------------------------
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic word_seen;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= word_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    assign word_seen = tog_s2 ^ tog_s3;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    sdw_mode_t next_mode;
    logic [7:0] next_code;

    always_comb begin
        next_mode = sdw_mode_t'({hold[MODE_HI_POS], hold[MODE_LO_POS]});
        next_code = hold[CODE_MSB_POS:CODE_LSB_POS];
    end

    // ----------------------------------------------------------------
    // Code and mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dac_code <= CODE_RESET;
        end else if (word_seen) begin
            dac_code <= next_code;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_mode <= MODE_RESET;
        end else if (word_seen) begin
            op_mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            written <= 1'b0;
            update <= 1'b0;
        end else begin
            update <= word_seen;
            if (word_seen) begin
                written <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output stage state
    // ----------------------------------------------------------------
    // Terminations follow the mode being loaded, so they change in the
    // same cycle as the mode register.
    sdw_mode_t eff_mode;
    logic [7:0] eff_code;

    always_comb begin
        eff_mode = word_seen ? next_mode : op_mode;
        eff_code = word_seen ? next_code : dac_code;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_down <= 1'b0;
            pull_1k_en <= 1'b0;
            pull_100k_en <= 1'b0;
            out_hiz <= 1'b0;
        end else begin
            case (eff_mode)
                SDW_NORMAL: begin
                    power_down <= 1'b0;
                    pull_1k_en <= 1'b0;
                    pull_100k_en <= 1'b0;
                    out_hiz <= 1'b0;
                end
                SDW_PD_1K: begin
                    power_down <= 1'b1;
                    pull_1k_en <= 1'b1;
                    pull_100k_en <= 1'b0;
                    out_hiz <= 1'b0;
                end
                SDW_PD_100K: begin
                    power_down <= 1'b1;
                    pull_1k_en <= 1'b0;
                    pull_100k_en <= 1'b1;
                    out_hiz <= 1'b0;
                end
                SDW_PD_HIZ: begin
                    power_down <= 1'b1;
                    pull_1k_en <= 1'b0;
                    pull_100k_en <= 1'b0;
                    out_hiz <= 1'b1;
                end
                default: begin
                    power_down <= 1'b1;
                    pull_1k_en <= 1'b0;
                    pull_100k_en <= 1'b0;
                    out_hiz <= 1'b1;
                end
            endcase
        end
    end

    // The analog path is off in power-down, so the level reads zero there
    // while dac_code still takes the code carried by each power-down word.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_mv <= 13'h0000;
        end else if (eff_mode == SDW_NORMAL) begin
            out_mv <= ideal_mv(eff_code);
        end else begin
            out_mv <= 13'h0000;
        end
    end

endmodule

/* src/sdw_pkg.sv */
package sdw_pkg;

    // ----------------------------------------------------------------
    // Word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 8;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int CODE_MSB_POS = 11;
    localparam int CODE_LSB_POS = 4;
    localparam logic [4:0] LAST_EDGE = 5'h0f;
    localparam logic [4:0] WORD_EDGES = 5'h10;
    localparam logic [7:0] CODE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_MIN_PERIOD_NS = 33;
    localparam int SYNC_HIGH_NS = 20;
    localparam logic [7:0] SYNC_HIGH_CYC =
        8'((SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SDW_NORMAL = 2'b00,
        SDW_PD_1K = 2'b01,
        SDW_PD_100K = 2'b10,
        SDW_PD_HIZ = 2'b11
    } sdw_mode_t;

    localparam sdw_mode_t MODE_RESET = SDW_NORMAL;

    // Builds the sixteen-bit word; the two leading and four trailing bits are zero.
    function automatic logic [15:0] sdw_pack(sdw_mode_t m, logic [7:0] c);
        logic [15:0] w;
        w = 16'h0000;
        w[MODE_HI_POS] = m[1];
        w[MODE_LO_POS] = m[0];
        w[CODE_MSB_POS:CODE_LSB_POS] = c;
        return w;
    endfunction

endpackage

/* src/sdw_link_if.sv */
interface sdw_link_if;
    logic frame_n;
    logic sclk;
    logic din;

    modport host (
        output frame_n,
        output sclk,
        output din
    );

    modport device (
        input frame_n,
        input sclk,
        input din
    );
endinterface

/* src/sdw_host.sv */
module sdw_host #(
    parameter int SCLK_HALF = 4
) (
    input wire logic ref_clk,                  // System clock.
    input wire logic sys_rst,                  // Asynchronous reset.
    sdw_link_if.host lnk,                      // Three-wire serial link.
    input wire logic req_valid,                // Write request.
    input wire sdw_pkg::sdw_mode_t req_mode,   // Mode to send.
    input wire logic [7:0] req_code,           // Code to send.
    input wire logic [4:0] req_edges,          // Edges to send, 1..16.
    output logic req_ready,                    // Idle, request accepted.
    output logic done                          // One-cycle pulse at end.
);
    import sdw_pkg::*;

    if (SCLK_HALF < 1 || SCLK_HALF > 255 ||
        2 * SCLK_HALF * CLK_PERIOD_NS < SCLK_MIN_PERIOD_NS) begin : g_bad_half
        $error("SCLK_HALF out of range");
    end

    localparam logic [7:0] HALF_CYC = 8'(SCLK_HALF - 1);

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_PREHI = 3'b001,
        H_START = 3'b010,
        H_HIGH = 3'b011,
        H_LOW = 3'b100,
        H_END = 3'b101
    } sdw_hstate_t;

    sdw_hstate_t state;
    logic [7:0] timer;
    logic [15:0] word;
    logic [4:0] edges;
    logic [4:0] sent;
    logic frame_n;
    logic sclk;
    logic din;

    assign lnk.frame_n = frame_n;
    assign lnk.sclk = sclk;
    assign lnk.din = din;

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    // Data changes as the clock rises and is sampled on the fall.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= H_IDLE;
            timer <= 8'h00;
            word <= 16'h0000;
            edges <= 5'h00;
            sent <= 5'h00;
            frame_n <= 1'b0;
            sclk <= 1'b0;
            din <= 1'b0;
            req_ready <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state != H_IDLE && timer != 8'h00) begin
                timer <= timer - 8'h01;
            end else begin
                case (state)
                    H_IDLE: begin
                        req_ready <= 1'b1;
                        if (req_valid && req_ready) begin
                            req_ready <= 1'b0;
                            word <= sdw_pack(req_mode, req_code);
                            edges <= (req_edges == 5'h00 || req_edges > WORD_EDGES) ?
                                WORD_EDGES : req_edges;
                            sent <= 5'h00;
                            frame_n <= 1'b1;
                            timer <= SYNC_HIGH_CYC - 8'h01;
                            state <= H_PREHI;
                        end
                    end
                    H_PREHI: begin
                        frame_n <= 1'b0;
                        timer <= HALF_CYC;
                        state <= H_START;
                    end
                    H_START: begin
                        din <= word[15];
                        word <= {word[14:0], 1'b0};
                        sclk <= 1'b1;
                        timer <= HALF_CYC;
                        state <= H_HIGH;
                    end
                    H_HIGH: begin
                        sclk <= 1'b0;
                        sent <= sent + 5'h01;
                        timer <= HALF_CYC;
                        state <= H_LOW;
                    end
                    H_LOW: begin
                        if (sent == edges) begin
                            frame_n <= 1'b1;
                            din <= 1'b0;
                            timer <= SYNC_HIGH_CYC - 8'h01;
                            state <= H_END;
                        end else begin
                            din <= word[15];
                            word <= {word[14:0], 1'b0};
                            sclk <= 1'b1;
                            timer <= HALF_CYC;
                            state <= H_HIGH;
                        end
                    end
                    H_END: begin
                        frame_n <= 1'b0;
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        state <= H_IDLE;
                    end
                    default: begin
                        frame_n <= 1'b0;
                        sclk <= 1'b0;
                        din <= 1'b0;
                        state <= H_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* verification/sdw_link_assertions.sv */
module sdw_link_assertions #(
    parameter int SUPPLY_MV = 3300
) (
    input wire logic ref_clk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic frame_n, // Frame.
    input wire logic sclk, // Link clock.
    input wire logic din, // Data.
    input wire logic [7:0] dac_code, // Code.
    input wire sdw_pkg::sdw_mode_t op_mode, // Mode.
    input wire logic power_down, // Shut down.
    input wire logic pull_1k_en, // 1k load.
    input wire logic pull_100k_en, // 100k load.
    input wire logic out_hiz, // Floating.
    input wire logic [12:0] out_mv, // Level.
    input wire logic written, // Written.
    input wire logic update // Pulse.
);
    timeunit 1ns;
    timeprecision 100ps;
    import sdw_pkg::*;
    logic sclk_q;
    logic frame_q;
    logic [4:0] fall_cnt;
    logic [15:0] shift_w;
    // --------------------
    // Counts and collects the bits of the current frame.
    // --------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            frame_q <= 1'b0;
            fall_cnt <= 5'h00;
            shift_w <= 16'h0000;
        end else begin
            sclk_q <= sclk;
            frame_q <= frame_n;
            if (frame_q && !frame_n) begin
                fall_cnt <= 5'h00;
            end else if (!frame_n && sclk_q && !sclk && fall_cnt < WORD_EDGES) begin
                fall_cnt <= fall_cnt + 5'h01;
                shift_w <= {shift_w[14:0], din};
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_last_fall;
        !frame_n && sclk_q && !sclk && fall_cnt == LAST_EDGE;
    endsequence
    sequence s_update_soon;
        ##[1:6] update;
    endsequence
    a_word_applied: assert property (s_last_fall |-> s_update_soon)
        else $error("no update after last edge");
    a_update_counted: assert property (update |-> fall_cnt == WORD_EDGES)
        else $error("update without sixteen edges");
    a_fields_loaded: assert property (update |-> dac_code == shift_w[11:4]
        && op_mode == shift_w[13:12])
        else $error("loaded fields differ from word");
    a_hold_between: assert property (!update |-> $stable(dac_code) && $stable(op_mode))
        else $error("state changed without update");
    a_blank_start: assert property (!written |-> dac_code == CODE_RESET && out_mv == 13'h0000)
        else $error("output not zero before write");
    a_mode_flags: assert property (power_down == (op_mode != SDW_NORMAL)
        && pull_1k_en == (op_mode == SDW_PD_1K) && pull_100k_en == (op_mode == SDW_PD_100K)
        && out_hiz == (op_mode == SDW_PD_HIZ))
        else $error("mode flags wrong");
    a_level_out: assert property (!power_down |-> out_mv == 13'((SUPPLY_MV * dac_code) / 256))
        else $error("output level wrong");
    a_idle_quiet: assert property (frame_n |-> !sclk && !din)
        else $error("link busy outside frame");
    a_pd_silent: assert property (power_down |-> out_mv == 13'h0000)
        else $error("output level not zero in power-down");
endmodule

/* verification/tb_serial_dac_write_port.sv */
module tb_serial_dac_write_port;
    timeunit 1ns;
    timeprecision 100ps;
    import sdw_pkg::*;
    typedef struct packed {
        sdw_mode_t mode;
        logic [7:0] code;
        logic [3:0] flags;
        logic [12:0] mv;
    } sdw_row_t;
    localparam int SUPPLY = 3300;
    localparam sdw_row_t ROWS [5] = '{
        '{SDW_NORMAL, 8'h80, 4'h0, 13'h0672},
        '{SDW_PD_1K, 8'h40, 4'hc, 13'h0000},
        '{SDW_PD_100K, 8'h40, 4'ha, 13'h0000},
        '{SDW_PD_HIZ, 8'h40, 4'h9, 13'h0000},
        '{SDW_NORMAL, 8'hff, 4'h0, 13'h0cd7}
    };
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    sdw_mode_t req_mode = SDW_NORMAL;
    logic [7:0] req_code = 8'h00;
    logic [4:0] req_edges = 5'h10;
    logic req_ready;
    logic done;
    logic [7:0] a_code;
    logic [7:0] b_code;
    sdw_mode_t a_mode;
    sdw_mode_t b_mode;
    wire logic [3:0] a_flags;
    logic [12:0] a_mv;
    logic a_written;
    logic b_written;
    logic a_update;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    sdw_link_if lnk_a ();
    sdw_link_if lnk_b ();
    sdw_host i_sdw_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk_a),
        .req_valid(req_valid), .req_mode(req_mode), .req_code(req_code),
        .req_edges(req_edges), .req_ready(req_ready), .done(done));
    sdw_device #(.SUPPLY_MV(SUPPLY)) i_sdw_device (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .lnk(lnk_a), .dac_code(a_code), .op_mode(a_mode), .power_down(a_flags[3]),
        .pull_1k_en(a_flags[2]), .pull_100k_en(a_flags[1]), .out_hiz(a_flags[0]),
        .out_mv(a_mv), .written(a_written), .update(a_update));
    sdw_device i_sdw_device_b (.ref_clk(ref_clk), .sys_rst(sys_rst), .lnk(lnk_b),
        .dac_code(b_code), .op_mode(b_mode), .power_down(), .pull_1k_en(),
        .pull_100k_en(), .out_hiz(), .out_mv(), .written(b_written), .update());
    sdw_link_assertions #(.SUPPLY_MV(SUPPLY)) i_sdw_link_assertions (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .frame_n(lnk_a.frame_n), .sclk(lnk_a.sclk), .din(lnk_a.din),
        .dac_code(a_code), .op_mode(a_mode), .power_down(a_flags[3]),
        .pull_1k_en(a_flags[2]), .pull_100k_en(a_flags[1]), .out_hiz(a_flags[0]),
        .out_mv(a_mv), .written(a_written), .update(a_update));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic report(logic [12:0] got, logic [12:0] exp);
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic check_code(logic [7:0] got, logic [7:0] exp);
        comparisons++;
        if (got !== exp) report(13'(got), 13'(exp));
    endtask
    task automatic check_level(logic [12:0] got, logic [12:0] exp);
        comparisons++;
        if (got !== exp) report(got, exp);
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // --------------------
    // Host requests and the bench's own link driver.
    // --------------------
    task automatic send(sdw_mode_t m, logic [7:0] c, logic [4:0] n);
        int k;
        k = 0;
        req_mode <= m;
        req_code <= c;
        req_edges <= n;
        req_valid <= 1'b1;
        @(posedge ref_clk);
        while (req_ready !== 1'b1) @(posedge ref_clk);
        req_valid <= 1'b0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        if (k == 400) begin
            errors++;
        end
        @(posedge ref_clk);
    endtask
    // Sends n bits MSB first at an 80 ns link period, then parks frame and data low.
    task automatic drive_link(logic [19:0] w, int n);
        lnk_b.frame_n = 1'b1;
        #40;
        lnk_b.frame_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #40;
            lnk_b.din = w[19 - i];
            lnk_b.sclk = 1'b1;
            #40;
            lnk_b.sclk = 1'b0;
        end
        #40;
        lnk_b.frame_n = 1'b1;
        lnk_b.din = 1'b0;
        #40;
        lnk_b.frame_n = 1'b0;
        #400;
        @(posedge ref_clk);
    endtask
    initial begin
        lnk_b.frame_n = 1'b0;
        lnk_b.sclk = 1'b0;
        lnk_b.din = 1'b0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        foreach (ROWS[r]) begin
            send(ROWS[r].mode, ROWS[r].code, 5'h10);
            check_code(a_code, ROWS[r].code);
            check_code(8'(a_mode), 8'(ROWS[r].mode));
            check_level(13'(a_flags), 13'(ROWS[r].flags));
            check_level(a_mv, ROWS[r].mv);
        end
        send(SDW_PD_HIZ, 8'h5a, 5'h0a);
        check_code(a_code, 8'hff);
        check_code(8'(a_mode), 8'(SDW_NORMAL));
        check_level(a_mv, 13'h0cd7);
        #3;
        drive_link({16'hca50, 4'hf}, 20);
        check_code(b_code, 8'ha5);
        check_code(8'(b_written), 8'h01);
        check_code(8'(b_mode), 8'(SDW_NORMAL));
        #3;
        drive_link({16'h3120, 4'h0}, 15);
        check_code(b_code, 8'ha5);
        check_code(8'(b_mode), 8'(SDW_NORMAL));
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check_code(a_code, CODE_RESET);
        check_code(b_code, CODE_RESET);
        check_level(13'({a_written, b_written}), 13'h0000);
        check_level(a_mv, 13'h0000);
        close_out();
    end
endmodule
